/* dpi_top.sv */
// dram pin interface: sampling, decode, power states, byte lanes, apb status
`timescale 1ns/1ns
`default_nettype none
module dpi_top (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic mem_reset_n_i,
   input wire logic clk_true_i,
   input wire logic clk_comp_i,
   input wire logic clk_gate_in_i,
   input wire logic chip_select_n_i,
   input wire logic row_strobe_n_i,
   input wire logic column_strobe_n_i,
   input wire logic write_cmd_n_i,
   input wire logic [2:0] bank_select_bits_i,
   input wire logic [13:0] addr_i,
   input wire logic die_termination_in_i,
   input wire logic [1:0] write_byte_mask_i,
   input wire logic [1:0] lane_strobe_i,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   output logic [1:0] lane_strobe_o,
   output logic [1:0] lane_strobe_oe_o,
   output logic lane_term_o
);
   localparam int LN = dpi_pkg::LANES;
   localparam int LW = dpi_pkg::LANE_W;
   localparam int NB = dpi_pkg::NBANK;

   dpi_pkg::dpi_pins_t pin_w;
   dpi_pkg::dpi_pins_t s1_q;
   dpi_pkg::dpi_pins_t s2_q;
   dpi_pkg::dpi_pins_t s3_q;
   dpi_pkg::dpi_pwr_t pwr_q;
   dpi_pkg::dpi_pwr_t pwr_d;
   dpi_pkg::dpi_cmd_t lcmd_q;
   logic [NB-1:0] open_q;
   logic [NB-1:0] open_d;
   logic [NB-1:0] bank_oh_w;
   logic [dpi_pkg::ADDR_W-1:0] mr_q [NB];
   logic term_q;
   logic [3:0] lat_q;
   logic [3:0] rd_wait_q;
   logic [3:0] rd_beats_q;
   logic [2:0] rd_bank_q;
   logic [3:0] wr_beats_q;
   logic [2:0] wr_bank_q;
   logic [LN*LW-1:0] dq_q;
   logic [LN*LW-1:0] rd_word_w;
   logic dqs_q;
   logic oe_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] rd_mux_w;
   logic [LN-1:0] strb_edge_w;

   assign pin_w = {mem_reset_n_i, clk_true_i, clk_comp_i, clk_gate_in_i, chip_select_n_i,
                   row_strobe_n_i, column_strobe_n_i, write_cmd_n_i, bank_select_bits_i,
                   addr_i, die_termination_in_i, write_byte_mask_i, lane_strobe_i, dq_i};

   // every pin crosses two flops; third stage only for edges
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   wire rst_w = rst_i | ~s2_q.rst_n;
   wire gate_w = s2_q.gate;
   // clock buffers off in self refresh
   wire live_w = pwr_q != dpi_pkg::PS_SREF;
   wire rise_w = live_w & s2_q.clk_t & ~s3_q.clk_t & ~s2_q.clk_c;
   wire fall_w = live_w & ~s2_q.clk_t & s3_q.clk_t & s2_q.clk_c;
   wire half_w = rise_w | fall_w;
   wire idle_w = open_q == '0;
   wire sel_w = rise_w & ~s2_q.cs_n;
   // command buffers live only when active and gate high
   wire cmd_ok_w = sel_w & gate_w & (pwr_q == dpi_pkg::PS_ACT);
   // decode on the same sampled edge
   wire is_mrs_w = cmd_ok_w & (s2_q.op == dpi_pkg::CMD_MRS);
   wire is_pre_w = cmd_ok_w & (s2_q.op == dpi_pkg::CMD_PRE);
   wire is_act_w = cmd_ok_w & (s2_q.op == dpi_pkg::CMD_ACT);
   wire is_wr_w = cmd_ok_w & (s2_q.op == dpi_pkg::CMD_WR);
   wire is_rd_w = cmd_ok_w & (s2_q.op == dpi_pkg::CMD_RD);
   wire ap_w = s2_q.a[dpi_pkg::AP_BIT];
   // chop bit low shortens the burst
   wire [3:0] bl_w = s2_q.a[dpi_pkg::BC_BIT] ? dpi_pkg::BL_FULL : dpi_pkg::BL_CHOP;
   wire pd_in_w = rise_w & ~gate_w & (pwr_q == dpi_pkg::PS_ACT);
   wire sref_in_w = pd_in_w & idle_w & sel_w & (s2_q.op == dpi_pkg::CMD_REF);
   wire term_on_w = mr_q[dpi_pkg::MR_ONE][dpi_pkg::MR1_TERM_BIT];

   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         dpi_pkg::PS_ACT: begin
            if (sref_in_w) begin
               pwr_d = dpi_pkg::PS_SREF;
            end else if (pd_in_w) begin
               pwr_d = idle_w ? dpi_pkg::PS_PPD : dpi_pkg::PS_APD;
            end
         end
         dpi_pkg::PS_PPD, dpi_pkg::PS_APD: begin
            if (rise_w & gate_w) begin
               pwr_d = dpi_pkg::PS_ACT;
            end
         end
         dpi_pkg::PS_SREF: begin
            if (gate_w) begin
               pwr_d = dpi_pkg::PS_ACT;
            end
         end
      endcase
   end

   assign bank_oh_w = NB'(1) << s2_q.bank;

   always_comb begin
      open_d = open_q;
      if (is_act_w) begin
         open_d = open_q | bank_oh_w;
      end else if (is_pre_w) begin
         open_d = ap_w ? '0 : (open_q & ~bank_oh_w);
      end else if ((is_rd_w | is_wr_w) & ap_w) begin
         open_d = open_q & ~bank_oh_w;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_w) begin
         pwr_q <= dpi_pkg::PS_ACT;
         open_q <= '0;
         lcmd_q <= '0;
      end else begin
         pwr_q <= pwr_d;
         open_q <= open_d;
         if (cmd_ok_w) begin
            lcmd_q <= {s2_q.op, s2_q.bank, s2_q.a};
         end
      end
   end

   // set cycle writes the register the bank bits name
   always_ff @(posedge core_clk_i) begin
      if (rst_w) begin
         for (int i = 0; i < NB; i++) begin
            mr_q[i] <= '0;
         end
      end else if (is_mrs_w) begin
         mr_q[s2_q.bank] <= s2_q.a;
      end
   end

   // termination pin registered at the crossing
   always_ff @(posedge core_clk_i) begin
      if (rst_w | ~live_w) begin
         term_q <= 1'b0;
      end else if (rise_w) begin
         // mode register one gates the pin
         term_q <= s2_q.term & term_on_w;
      end
   end

   // read beats advance on crossings only
   always_ff @(posedge core_clk_i) begin
      if (rst_w) begin
         rd_wait_q <= '0;
         rd_beats_q <= '0;
         rd_bank_q <= '0;
         dq_q <= '0;
         dqs_q <= 1'b0;
      end else if (is_rd_w) begin
         rd_wait_q <= lat_q;
         rd_beats_q <= bl_w;
         rd_bank_q <= s2_q.bank;
      end else if (half_w && rd_wait_q != '0) begin
         rd_wait_q <= rd_wait_q - 4'h1;
      end else if (half_w && rd_beats_q != '0) begin
         rd_beats_q <= rd_beats_q - 4'h1;
         dq_q <= rd_word_w;
         dqs_q <= ~dqs_q;
      end
   end

   // drivers off while gate low; burst counters keep running
   always_ff @(posedge core_clk_i) begin
      if (rst_w | ~gate_w) begin
         oe_q <= 1'b0;
      end else if (half_w) begin
         oe_q <= (rd_wait_q == '0) && (rd_beats_q != '0);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_w) begin
         wr_beats_q <= '0;
         wr_bank_q <= '0;
      end else if (is_wr_w) begin
         wr_beats_q <= bl_w;
         wr_bank_q <= s2_q.bank;
      end else if (strb_edge_w[0] && wr_beats_q != '0) begin
         wr_beats_q <= wr_beats_q - 4'h1;
      end
   end

   wire wr_on_w = (wr_beats_q != '0) & gate_w;

   // one storage column per byte lane
   for (genvar l = 0; l < LN; l++) begin : g_lane
      logic [LW-1:0] mem_q [NB];
      assign strb_edge_w[l] = s2_q.strb[l] ^ s3_q.strb[l];
      assign rd_word_w[l*LW +: LW] = mem_q[rd_bank_q];
      // masked bytes dropped; data centred on strobe edge
      always_ff @(posedge core_clk_i) begin
         if (wr_on_w & strb_edge_w[l] & ~s2_q.mask[l]) begin
            mem_q[wr_bank_q] <= s2_q.dq[l*LW +: LW];
         end
      end
   end

   // apb slave, one wait state
   wire acc_w = psel_i & penable_i & ~pready_q;
   wire done_w = psel_i & penable_i & pready_q;
   wire hit_ctrl_w = paddr_i == dpi_pkg::ADDR_CTRL;
   wire hit_stat_w = paddr_i == dpi_pkg::ADDR_STAT;
   wire hit_lcmd_w = paddr_i == dpi_pkg::ADDR_LCMD;
   wire hit_w = hit_ctrl_w | hit_stat_w | hit_lcmd_w;
   assign rd_mux_w = hit_ctrl_w ? 32'(lat_q) :
                     hit_stat_w ? 32'({term_q, open_q, pwr_q}) :
                     hit_lcmd_w ? 32'(lcmd_q) : '0;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= acc_w;
         pslverr_q <= acc_w & ~hit_w;
         prdata_q <= acc_w ? rd_mux_w : prdata_q;
      end
   end

   // latency survives memory reset: software owns it
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lat_q <= dpi_pkg::RD_LAT_RST;
      end else if (done_w & pwrite_i & hit_ctrl_w) begin
         lat_q <= pwdata_i[3:0];
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign dq_o = dq_q;
   assign dq_oe_o = oe_q;
   assign lane_strobe_o = {LN{dqs_q}};
   assign lane_strobe_oe_o = {LN{oe_q}};
   assign lane_term_o = term_q;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_w);

   sequence s_chop;
      is_rd_w && !s2_q.a[dpi_pkg::BC_BIT];
   endsequence
   property p_capt;
      cmd_ok_w |=> lcmd_q.a == $past(s2_q.a) && lcmd_q.op == $past(s2_q.op);
   endproperty
   a_capt: assert property (p_capt) else $error("command not captured");
   property p_rd_edge;
      $changed(dqs_q) |-> $past(half_w);
   endproperty
   a_rd_edge: assert property (p_rd_edge) else $error("strobe moved off crossing");
   property p_gate;
      !gate_w |=> !oe_q;
   endproperty
   a_gate: assert property (p_gate) else $error("driving with gate low");
   property p_apd;
      pd_in_w && !idle_w |=> pwr_q == dpi_pkg::PS_APD;
   endproperty
   a_apd: assert property (p_apd) else $error("wrong power-down kind");
   property p_sref_out;
      pwr_q == dpi_pkg::PS_SREF && gate_w |=> pwr_q == dpi_pkg::PS_ACT;
   endproperty
   a_sref_out: assert property (p_sref_out) else $error("no self refresh exit");
   property p_pd_cmd;
      pwr_q != dpi_pkg::PS_ACT |-> !cmd_ok_w;
   endproperty
   a_pd_cmd: assert property (p_pd_cmd) else $error("command in low power");
   property p_sref_clk;
      pwr_q == dpi_pkg::PS_SREF |-> !half_w;
   endproperty
   a_sref_clk: assert property (p_sref_clk) else $error("clock seen in self refresh");
   property p_cs;
      s2_q.cs_n |-> !cmd_ok_w;
   endproperty
   a_cs: assert property (p_cs) else $error("masked command taken");
   property p_term;
      rise_w && !term_on_w |=> !term_q;
   endproperty
   a_term: assert property (p_term) else $error("termination while disabled");
   property p_bank;
      is_act_w |=> open_q[$past(s2_q.bank)];
   endproperty
   a_bank: assert property (p_bank) else $error("bank not opened");
   property p_chop;
      s_chop |=> rd_beats_q == dpi_pkg::BL_CHOP;
   endproperty
   a_chop: assert property (p_chop) else $error("chop not applied");
endmodule
`default_nettype wire

/* dpi_pkg.sv */
// shared constants and types of the dram pin interface
package dpi_pkg;
   // apb register byte offsets and the read latency reset value
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_LCMD = 8'h08;
   localparam logic [3:0] RD_LAT_RST = 4'h1;

   // burst lengths in beats
   localparam logic [3:0] BL_FULL = 4'h8;
   localparam logic [3:0] BL_CHOP = 4'h4;

   localparam int LANES = 2;
   localparam int LANE_W = 8;
   localparam int NBANK = 8;
   localparam int BANK_W = 3;
   localparam int ADDR_W = 14;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam int MR1_TERM_BIT = 2;
   localparam logic [BANK_W-1:0] MR_ONE = 3'h1;

   // {row, column, write} strobe codes, active low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;

   typedef enum logic [1:0] {PS_ACT, PS_PPD, PS_APD, PS_SREF} dpi_pwr_t;

   typedef struct packed {
      logic rst_n;
      logic clk_t;
      logic clk_c;
      logic gate;
      logic cs_n;
      logic [2:0] op;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] a;
      logic term;
      logic [LANES-1:0] mask;
      logic [LANES-1:0] strb;
      logic [LANES*LANE_W-1:0] dq;
   } dpi_pins_t;

   typedef struct packed {
      logic [2:0] op;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] a;
   } dpi_cmd_t;
endpackage

/* dpi_ctl_model.sv */
// memory controller model driving the dram pins
`timescale 1ns/1ns
`default_nettype none
module dpi_ctl_model (
   output var dpi_pkg::dpi_pins_t pins_o
);
   dpi_pkg::dpi_pins_t p;
   logic run;
   assign pins_o = p;
   // reset pin held high in normal use
   initial begin
      p = '0;
      p.rst_n = 1'h1;
      p.clk_c = 1'h1;
      p.cs_n = 1'h1;
      p.op = 3'h7;
      p.gate = 1'h1;
      run = 1'h1;
   end
   always begin
      #62 if (run || p.clk_t) p.clk_t = ~p.clk_t;
      p.clk_c = ~p.clk_t;
      #63 if (run || p.clk_t) p.clk_t = ~p.clk_t;
      p.clk_c = ~p.clk_t;
   end
   // select and strobes held over one crossing
   task automatic cmd(input logic cs, input logic [2:0] op, input logic [2:0] b, input logic [13:0] a,
                      input logic g);
      @(negedge p.clk_t);
      p.cs_n = cs;
      p.op = op;
      p.bank = b;
      p.a = a;
      p.gate = g;
      @(negedge p.clk_t);
      p.cs_n = 1'h1;
      p.op = ~op;
      p.bank = ~b;
      p.a = ~a;
   endtask
   task automatic wr_burst(input logic [2:0] b, input logic [13:0] a, input logic [15:0] base,
                           input logic [15:0] mk);
      cmd(1'h0, dpi_pkg::CMD_WR, b, a, 1'h1);
      for (int k = 0; k < (a[12] ? 8 : 4); k++) begin
         p.dq = base + 16'(k) * 16'h0101;
         p.mask = mk[2*k+:2];
         #32 p.strb = ~p.strb;
         #32;
      end
      // released lines must not keep the last beat
      p.dq = ~p.dq;
      p.mask = 2'h3;
   endtask
   task automatic term(input logic v);
      @(negedge p.clk_t);
      p.term = v;
      @(negedge p.clk_t);
   endtask
   // gate raised with the clock standing still
   task automatic wake_still;
      run = 1'h0;
      #250 p.gate = 1'h1;
      #250;
   endtask
   task automatic mem_reset;
      @(negedge p.clk_t);
      p.rst_n = 1'h0;
      @(negedge p.clk_t);
      p.rst_n = 1'h1;
      @(negedge p.clk_t);
   endtask
endmodule
`default_nettype wire

/* dpi_top_tb_top.sv */
// self-checking bench for the dram pin interface
`timescale 1ns/1ns
`default_nettype none
module dpi_top_tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] dq_o;
   logic dq_oe;
   logic [1:0] strb_o;
   logic [1:0] strb_oe;
   logic term_o;
   dpi_pkg::dpi_pins_t pins;
   int num_errors = 0;
   int comparisons = 0;
   always #4 clk = ~clk;
   dpi_ctl_model dpi_ctl_model_inst (.pins_o(pins));
   dpi_top dpi_top_inst (
      .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .mem_reset_n_i(pins.rst_n), .clk_true_i(pins.clk_t), .clk_comp_i(pins.clk_c),
      .clk_gate_in_i(pins.gate), .chip_select_n_i(pins.cs_n), .row_strobe_n_i(pins.op[2]),
      .column_strobe_n_i(pins.op[1]), .write_cmd_n_i(pins.op[0]), .bank_select_bits_i(pins.bank),
      .addr_i(pins.a), .die_termination_in_i(pins.term), .write_byte_mask_i(pins.mask),
      .lane_strobe_i(pins.strb), .dq_i(pins.dq), .dq_o(dq_o), .dq_oe_o(dq_oe),
      .lane_strobe_o(strb_o), .lane_strobe_oe_o(strb_oe), .lane_term_o(term_o));
   task automatic conclude;
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic hang(input string what);
      chk(what, 32'h1, 32'h0);
      conclude();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 100);
      if (n >= 100) hang("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic e;
      apb(1'h0, a, 32'h0, d, e);
      chk(what, exp, d & m);
   endtask
   task automatic tchk(input logic exp, input string what);
      // termination is only re-sampled at a crossing, so let one pass and settle
      @(posedge pins.clk_t);
      repeat (6) @(posedge clk);
      chk(what, {31'h0, exp}, {31'h0, term_o});
   endtask
   task automatic issue(input logic [2:0] op, input logic [2:0] b, input logic [13:0] a);
      dpi_ctl_model_inst.cmd(1'h0, op, b, a, 1'h1);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic e;
      rchk(dpi_pkg::ADDR_CTRL, 32'hF, 32'(dpi_pkg::RD_LAT_RST), "ctrl reset");
      rchk(dpi_pkg::ADDR_STAT, 32'h7FF, 32'h0, "stat reset");
      apb(1'h0, 8'h0C, 32'h0, d, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
      apb(1'h1, dpi_pkg::ADDR_STAT, 32'hFFFFFFFF, d, e);
      rchk(dpi_pkg::ADDR_STAT, 32'h7FF, 32'h0, "stat ro");
      apb(1'h1, dpi_pkg::ADDR_CTRL, 32'h2, d, e);
      rchk(dpi_pkg::ADDR_CTRL, 32'hF, 32'h2, "ctrl rw");
   endtask
   task automatic t_cmd;
      issue(dpi_pkg::CMD_ACT, 3'h5, 14'h1234);
      rchk(dpi_pkg::ADDR_LCMD, 32'hFFFFF, {12'h0, dpi_pkg::CMD_ACT, 3'h5, 14'h1234}, "last cmd");
      dpi_ctl_model_inst.cmd(1'h1, dpi_pkg::CMD_ACT, 3'h3, 14'h0, 1'h1);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FC, 32'h80, "deselected act");
      issue(dpi_pkg::CMD_ACT, 3'h2, 14'h0);
      issue(dpi_pkg::CMD_PRE, 3'h5, 14'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FC, 32'h10, "one bank pre");
      issue(dpi_pkg::CMD_ACT, 3'h6, 14'h0);
      issue(dpi_pkg::CMD_PRE, 3'h0, 14'h0400);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FC, 32'h0, "all bank pre");
   endtask
   task automatic t_read(input logic [2:0] b, input logic [13:0] a, input logic [15:0] exp);
      int n;
      int k;
      logic [1:0] s;
      k = 0;
      s = 2'h0;
      issue(dpi_pkg::CMD_RD, b, a);
      for (n = 0; n < 600 && !(k > 0 && dq_oe !== 1'h1); n++) begin
         @(posedge clk);
         if (dq_oe === 1'h1 && strb_o !== s) begin
            chk("read beat", {16'h0, exp}, {16'h0, dq_o});
            chk("strobe", {28'h0, 2'h3, {2{~s[0]}}}, {28'h0, strb_oe, strb_o});
            s = strb_o;
            k++;
         end
      end
      if (n >= 600) hang("read end");
      chk("beats", a[12] ? 32'h8 : 32'h4, 32'(k));
   endtask
   task automatic t_data;
      issue(dpi_pkg::CMD_ACT, 3'h2, 14'h0);
      dpi_ctl_model_inst.wr_burst(3'h2, 14'h1000, 16'h5A10, 16'hE000);
      t_read(3'h2, 14'h0000, 16'h5F16);
      dpi_ctl_model_inst.wr_burst(3'h2, 14'h0000, 16'h2301, 16'h0000);
      t_read(3'h2, 14'h1400, 16'h2604);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FC, 32'h0, "autoprecharge");
   endtask
   task automatic t_term;
      dpi_ctl_model_inst.term(1'h1);
      tchk(1'h0, "term mr off");
      issue(dpi_pkg::CMD_MRS, 3'h0, 14'h0004);
      tchk(1'h0, "term other mr");
      issue(dpi_pkg::CMD_MRS, dpi_pkg::MR_ONE, 14'h0004);
      tchk(1'h1, "term on");
      rchk(dpi_pkg::ADDR_STAT, 32'h400, 32'h400, "stat term");
      dpi_ctl_model_inst.term(1'h0);
      tchk(1'h0, "term pin low");
      dpi_ctl_model_inst.term(1'h1);
   endtask
   task automatic t_power;
      dpi_ctl_model_inst.cmd(1'h1, 3'h7, 3'h0, 14'h0, 1'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FF, 32'h1, "precharge pd");
      dpi_ctl_model_inst.term(1'h0);
      tchk(1'h0, "term in pd");
      dpi_ctl_model_inst.term(1'h1);
      dpi_ctl_model_inst.cmd(1'h0, dpi_pkg::CMD_ACT, 3'h4, 14'h0, 1'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FF, 32'h1, "cmd in pd");
      dpi_ctl_model_inst.cmd(1'h1, 3'h7, 3'h0, 14'h0, 1'h1);
      issue(dpi_pkg::CMD_ACT, 3'h4, 14'h0);
      dpi_ctl_model_inst.cmd(1'h1, 3'h7, 3'h0, 14'h0, 1'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h3FF, 32'h42, "active pd");
      dpi_ctl_model_inst.cmd(1'h1, 3'h7, 3'h0, 14'h0, 1'h1);
      issue(dpi_pkg::CMD_PRE, 3'h0, 14'h0400);
      dpi_ctl_model_inst.cmd(1'h0, dpi_pkg::CMD_REF, 3'h0, 14'h0, 1'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h7FF, 32'h3, "self refresh");
      tchk(1'h0, "term in sref");
      dpi_ctl_model_inst.wake_still();
      rchk(dpi_pkg::ADDR_STAT, 32'h3, 32'h0, "sref exit");
      dpi_ctl_model_inst.run = 1'h1;
   endtask
   task automatic t_memrst;
      issue(dpi_pkg::CMD_ACT, 3'h1, 14'h0);
      rchk(dpi_pkg::ADDR_STAT, 32'h7FF, 32'h408, "before reset");
      dpi_ctl_model_inst.mem_reset();
      rchk(dpi_pkg::ADDR_STAT, 32'h7FF, 32'h0, "after reset");
      tchk(1'h0, "term after reset");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      t_regs();
      t_cmd();
      t_data();
      t_term();
      t_power();
      t_memrst();
      conclude();
   end
endmodule
`default_nettype wire
